// ==== shared/plc_pkg.sv ====
// Package for the per-port link capability and link control register pair.
// Assumes one core clock and an AXI4-Lite master with an 8-bit byte address.
package plc_pkg;
    // Register byte addresses
    localparam logic [7:0] PLC_OFS_CAP = 8'hCC;
    localparam logic [7:0] PLC_OFS_CTL = 8'hD0;
    // Capability field positions
    localparam int PLC_SPD_LSB = 0;
    localparam int PLC_WID_LSB = 4;
    localparam int PLC_ASUP_LSB = 10;
    localparam int PLC_L0S_LSB = 12;
    localparam int PLC_L1_LSB = 15;
    localparam int PLC_CLKPM_BIT = 18;
    localparam int PLC_SDN_BIT = 19;
    localparam int PLC_DLLA_BIT = 20;
    localparam int PLC_BWN_BIT = 21;
    localparam int PLC_PNUM_LSB = 24;
    // Control and status field positions
    localparam int PLC_ASPMC_LSB = 0;
    localparam int PLC_RCB_BIT = 3;
    localparam int PLC_LDIS_BIT = 4;
    localparam int PLC_RETR_BIT = 5;
    localparam int PLC_LTRN_BIT = 27;
    // Encodings and reset values
    localparam logic [3:0] PLC_SPD_2G5 = 4'h1;
    localparam logic [3:0] PLC_SPD_5G0 = 4'h2;
    localparam logic [3:0] PLC_SPD_RST = PLC_SPD_5G0;
    localparam logic [5:0] PLC_WID_RST = 6'h01;
    localparam logic [1:0] PLC_ASUP_RST = 2'h3;
    localparam logic [2:0] PLC_L0S_RST = 3'h3;
    localparam logic [2:0] PLC_L1_RST = 3'h0;
    localparam logic [1:0] PLC_ASPM_OFF = 2'h0;
    localparam logic [1:0] PLC_ASPM_L0S = 2'h1;
    localparam logic [1:0] PLC_ASPM_L1 = 2'h2;
    localparam logic [1:0] PLC_ASPM_BOTH = 2'h3;
    localparam logic [1:0] PLC_ASPMC_RST = PLC_ASPM_OFF;
    localparam logic [1:0] PLC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PLC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } plc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } plc_axi_rsp_t;

    typedef struct packed {
        logic [1:0] aspm_sup;
        logic [2:0] l0s_lat;
        logic [2:0] l1_lat;
        logic clkpm;
        logic [7:0] port_num;
    } plc_cap_load_t;

    typedef struct packed {
        logic [1:0] aspm_ctl;
        logic link_disable;
        logic retrain;
        logic rx_l0s_ok;
    } plc_link_ctl_t;
endpackage

// ==== hdl/plc_regs.sv ====
// Link capability and link control registers of one switch port, AXI4-Lite slave.
// Assumes a single 250 MHz core clock and a loader that presents strap values.
// Contract
// - Max link speed bits 3:0 read 2 (5.0 Gb/s); 1 means 2.5 Gb/s, other codes reserved.
// - Max link width bits 9:4 read 1, a single lane.
// - ASPM support bits 11:10 reset to 3, L0s and L1 both supported.
// - L0s exit latency bits 14:12 reset to 3, 256 ns up to under 512 ns.
// - L1 exit latency bits 17:15 reset to 0, less than 1 us.
// - Clock PM bit 18 resets to 1 on the upstream port and 0 on downstream ports.
// - Surprise-down bit 19 and bandwidth notify bit 21 read 0 upstream and 1 downstream.
// - DL active reporting bit 20 reads 0 on every port.
// - Port number bits 31:24 reset to the port index 0, 1 or 2.
// - ASPM support, both latencies, clock PM and port number can be reloaded.
// - ASPM control bits 1:0 are writable, 0 off, 1 L0s, 2 L1, 3 both, reset 0.
// - The receiver may enter L0s whatever the ASPM control setting.
// - Read completion boundary bit 3 always reads 0.
// - Link disable bit 4 disables a downstream link, is stuck at 0 upstream, resets 0.
// - Retrain bit 5 starts retraining downstream and is stuck at 0 upstream.
// - Link training bit 27 reads 1 while training runs and clears when it ends.
module plc_regs #(
    parameter bit IS_UPSTREAM = 1'b1,
    parameter logic [7:0] PORT_NUM = 8'h00
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire plc_pkg::plc_axi_req_t axi_i,
    output plc_pkg::plc_axi_rsp_t axi_o,
    // Default loader
    input wire logic cap_load_valid_i,
    input wire plc_pkg::plc_cap_load_t cap_load_i,
    // Link layer
    input wire logic training_i,
    output plc_pkg::plc_link_ctl_t link_ctl_o
);
    import plc_pkg::*;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    typedef struct packed {
        plc_axi_rsp_t rsp;
        logic aw_have;
        logic [7:0] waddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic rd_cap;
        logic rd_ctl;
        plc_cap_load_t cap;
        logic cap_loaded;
        plc_link_ctl_t ctl;
        logic training;
    } plc_state_t;

    localparam plc_cap_load_t CAP_RST = '{
        aspm_sup: PLC_ASUP_RST,
        l0s_lat: PLC_L0S_RST,
        l1_lat: PLC_L1_RST,
        clkpm: IS_UPSTREAM,
        port_num: PORT_NUM
    };

    localparam plc_state_t ST_RST = '{
        rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
        cap: CAP_RST,
        ctl: '{aspm_ctl: PLC_ASPMC_RST, rx_l0s_ok: 1'b1, default: 1'b0},
        default: '0
    };

    plc_state_t q;
    plc_state_t d;

    function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    function automatic logic [31:0] cap_word(input plc_state_t s);
        logic [31:0] w;
        w = '0;
        w[PLC_SPD_LSB +: 4] = PLC_SPD_RST;
        w[PLC_WID_LSB +: 6] = PLC_WID_RST;
        w[PLC_ASUP_LSB +: 2] = s.cap.aspm_sup;
        w[PLC_L0S_LSB +: 3] = s.cap.l0s_lat;
        w[PLC_L1_LSB +: 3] = s.cap.l1_lat;
        w[PLC_CLKPM_BIT] = s.cap.clkpm;
        w[PLC_SDN_BIT] = !IS_UPSTREAM;
        w[PLC_DLLA_BIT] = 1'b0;
        w[PLC_BWN_BIT] = !IS_UPSTREAM;
        w[PLC_PNUM_LSB +: 8] = s.cap.port_num;
        return w;
    endfunction

    function automatic logic [31:0] ctl_word(input plc_state_t s);
        logic [31:0] w;
        w = '0;
        w[PLC_ASPMC_LSB +: 2] = s.ctl.aspm_ctl;
        w[PLC_RCB_BIT] = 1'b0;
        w[PLC_LDIS_BIT] = s.ctl.link_disable;
        w[PLC_RETR_BIT] = 1'b0;
        w[PLC_LTRN_BIT] = s.training;
        return w;
    endfunction

    always_comb begin
        d = q;
        d.ctl.retrain = 1'b0;
        d.ctl.rx_l0s_ok = 1'b1;
        d.training = training_i;
        if (cap_load_valid_i) begin
            d.cap = cap_load_i;
            d.cap_loaded = 1'b1;
        end
        // Write channels may arrive in either order
        if (axi_i.awvalid && q.rsp.awready) begin
            d.aw_have = 1'b1;
            d.waddr = axi_i.awaddr;
        end
        if (axi_i.wvalid && q.rsp.wready) begin
            d.w_have = 1'b1;
            d.wdata = axi_i.wdata;
            d.wstrb = axi_i.wstrb;
        end
        if (q.rsp.bvalid && axi_i.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = PLC_RESP_SLVERR;
            if (word_hit(q.waddr, PLC_OFS_CAP)) begin
                d.rsp.bresp = PLC_RESP_OKAY;
            end
            if (word_hit(q.waddr, PLC_OFS_CTL)) begin
                d.rsp.bresp = PLC_RESP_OKAY;
                if (q.wstrb[0]) begin
                    d.ctl.aspm_ctl = q.wdata[PLC_ASPMC_LSB +: 2];
                    if (!IS_UPSTREAM) begin
                        d.ctl.link_disable = q.wdata[PLC_LDIS_BIT];
                        d.ctl.retrain = q.wdata[PLC_RETR_BIT];
                    end
                end
            end
        end
        d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
        d.rsp.wready = !d.w_have && !d.rsp.bvalid;
        // Read channel
        if (q.rsp.rvalid && axi_i.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (axi_i.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rd_cap = word_hit(axi_i.araddr, PLC_OFS_CAP);
            d.rd_ctl = word_hit(axi_i.araddr, PLC_OFS_CTL);
            d.rsp.rdata = '0;
            d.rsp.rresp = PLC_RESP_SLVERR;
            if (d.rd_cap) begin
                d.rsp.rdata = cap_word(q);
                d.rsp.rresp = PLC_RESP_OKAY;
            end
            if (d.rd_ctl) begin
                d.rsp.rdata = ctl_word(q);
                d.rsp.rresp = PLC_RESP_OKAY;
            end
        end
        d.rsp.arready = !d.rsp.rvalid;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign axi_o = q.rsp;
    assign link_ctl_o = q.ctl;

    // A control write that lands at the next edge
    logic ctl_commit;
    assign ctl_commit = q.aw_have && q.w_have && !q.rsp.bvalid &&
        word_hit(q.waddr, PLC_OFS_CTL) && q.wstrb[0];

    // Steps of a write commit and of a read take
    sequence s_wr_commit;
        q.aw_have && q.w_have && !q.rsp.bvalid;
    endsequence

    sequence s_wr_ctl;
        s_wr_commit and (word_hit(q.waddr, PLC_OFS_CTL) && q.wstrb[0]);
    endsequence

    sequence s_wr_stray;
        s_wr_commit and (!word_hit(q.waddr, PLC_OFS_CAP) && !word_hit(q.waddr, PLC_OFS_CTL));
    endsequence

    sequence s_rd_take;
        axi_i.arvalid && q.rsp.arready;
    endsequence

    sequence s_rd_cap_take;
        s_rd_take and word_hit(axi_i.araddr, PLC_OFS_CAP);
    endsequence

    sequence s_rd_ctl_take;
        s_rd_take and word_hit(axi_i.araddr, PLC_OFS_CTL);
    endsequence

    // Write channel
    chk_resp_hold: assert property (q.rsp.bvalid && !axi_i.bready |=> q.rsp.bvalid)
        else $error("write response dropped before bready");
    chk_resp_stable: assert property (q.rsp.bvalid && !axi_i.bready |=> $stable(q.rsp.bresp))
        else $error("write response code changed while waiting");
    chk_wr_resp: assert property (s_wr_commit |=> q.rsp.bvalid && !q.aw_have && !q.w_have)
        else $error("write not answered one cycle after both halves");
    chk_b_cause: assert property ($rose(q.rsp.bvalid) |-> $past(q.aw_have && q.w_have))
        else $error("write response without both halves");
    chk_wr_halves: assert property (q.rsp.bvalid |-> !q.aw_have && !q.w_have)
        else $error("write halves captured while a response waits");
    chk_aw_stall: assert property (q.aw_have || q.rsp.bvalid |-> !q.rsp.awready)
        else $error("write address accepted while a write is pending");
    chk_w_stall: assert property (q.w_have || q.rsp.bvalid |-> !q.rsp.wready)
        else $error("write data accepted while a write is pending");
    chk_wr_okay: assert property (s_wr_ctl |=> q.rsp.bresp == PLC_RESP_OKAY)
        else $error("control write not answered OKAY");
    chk_wr_cap_okay: assert property ((s_wr_commit and word_hit(q.waddr, PLC_OFS_CAP)) |=>
        q.rsp.bresp == PLC_RESP_OKAY)
        else $error("capability write not answered OKAY");
    chk_wr_stray: assert property (s_wr_stray |=> q.rsp.bresp == PLC_RESP_SLVERR)
        else $error("unmapped write not refused");

    // Read channel
    chk_rd_answer: assert property (s_rd_take |=> q.rsp.rvalid && !q.rsp.arready)
        else $error("read not answered one cycle after the address");
    chk_ar_stall: assert property (q.rsp.rvalid |-> !q.rsp.arready)
        else $error("read address accepted while read data waits");
    chk_rd_idle: assert property (!q.rsp.rvalid |-> q.rsp.arready)
        else $error("read address refused while idle");
    chk_rd_hold: assert property (q.rsp.rvalid && !axi_i.rready |=>
        q.rsp.rvalid && $stable(q.rsp.rdata) && $stable(q.rsp.rresp))
        else $error("read answer changed before rready");
    chk_rd_okay: assert property (q.rsp.rvalid && (q.rd_cap || q.rd_ctl) |->
        q.rsp.rresp == PLC_RESP_OKAY)
        else $error("mapped read not answered OKAY");
    chk_rd_stray: assert property (q.rsp.rvalid && !q.rd_cap && !q.rd_ctl |->
        q.rsp.rresp == PLC_RESP_SLVERR && q.rsp.rdata == '0)
        else $error("unmapped read not refused");

    // Capability word
    chk_cap_fixed: assert property (q.rsp.rvalid && q.rd_cap |->
        q.rsp.rdata[PLC_SPD_LSB +: 4] == PLC_SPD_RST &&
        q.rsp.rdata[PLC_WID_LSB +: 6] == PLC_WID_RST)
        else $error("capability speed or width wrong");
    chk_cap_side: assert property (q.rsp.rvalid && q.rd_cap |->
        q.rsp.rdata[PLC_SDN_BIT] == !IS_UPSTREAM && !q.rsp.rdata[PLC_DLLA_BIT] &&
        q.rsp.rdata[PLC_BWN_BIT] == !IS_UPSTREAM)
        else $error("capability port-side bits wrong");
    chk_cap_defaults: assert property (!q.cap_loaded |-> q.cap == CAP_RST)
        else $error("capability defaults changed without a load");
    chk_cap_ro: assert property (!cap_load_valid_i |=> $stable(q.cap))
        else $error("capability fields changed without a load");
    chk_cap_reload: assert property (cap_load_valid_i |=> q.cap == $past(cap_load_i))
        else $error("loaded defaults not taken");
    chk_cap_read: assert property (s_rd_cap_take |=>
        q.rsp.rdata[PLC_ASUP_LSB +: 2] == $past(q.cap.aspm_sup) &&
        q.rsp.rdata[PLC_L0S_LSB +: 3] == $past(q.cap.l0s_lat) &&
        q.rsp.rdata[PLC_L1_LSB +: 3] == $past(q.cap.l1_lat) &&
        q.rsp.rdata[PLC_CLKPM_BIT] == $past(q.cap.clkpm) &&
        q.rsp.rdata[PLC_PNUM_LSB +: 8] == $past(q.cap.port_num))
        else $error("capability word does not show the stored fields");

    // Control word
    chk_aspm_write: assert property (s_wr_ctl |=>
        q.ctl.aspm_ctl == $past(q.wdata[PLC_ASPMC_LSB +: 2]))
        else $error("aspm control not written");
    chk_ctl_hold: assert property (!ctl_commit |=>
        $stable(q.ctl.aspm_ctl) && $stable(q.ctl.link_disable))
        else $error("control changed without a write");
    chk_ctl_read: assert property (s_rd_ctl_take |=>
        q.rsp.rdata[PLC_ASPMC_LSB +: 2] == $past(q.ctl.aspm_ctl) &&
        q.rsp.rdata[PLC_LDIS_BIT] == $past(q.ctl.link_disable))
        else $error("control word does not show the stored fields");
    chk_l0s_rx: assert property (q.ctl.rx_l0s_ok)
        else $error("receiver L0s entry blocked");
    chk_ctl_ro: assert property (q.rsp.rvalid && q.rd_ctl |->
        !q.rsp.rdata[PLC_RCB_BIT] && !q.rsp.rdata[PLC_RETR_BIT])
        else $error("read-only control bits read nonzero");
    chk_ldis_write: assert property (!IS_UPSTREAM && ctl_commit |=>
        q.ctl.link_disable == $past(q.wdata[PLC_LDIS_BIT]))
        else $error("link disable not written");
    chk_up_locked: assert property (IS_UPSTREAM |->
        !q.ctl.link_disable && !q.ctl.retrain)
        else $error("upstream link disable or retrain set");
    chk_retrain_dn: assert property (!IS_UPSTREAM && ctl_commit &&
        q.wdata[PLC_RETR_BIT] |=> q.ctl.retrain)
        else $error("retrain write did not start retraining");
    chk_retrain_src: assert property (q.ctl.retrain |->
        $past(q.aw_have && q.w_have && q.wdata[PLC_RETR_BIT] && q.wstrb[0]))
        else $error("retrain without a write");
    chk_retrain_pulse: assert property (q.ctl.retrain |=> !q.ctl.retrain)
        else $error("retrain request longer than one cycle");
    chk_train_read: assert property (s_rd_ctl_take |=>
        q.rsp.rdata[PLC_LTRN_BIT] == $past(q.training))
        else $error("link training bit does not follow training");
endmodule // plc_regs

// ==== tb/test_plc_regs.sv ====
// Self-checking bench for the link capability and link control registers.
// Assumes an upstream port 0 and a downstream port 2, each on its own AXI4-Lite bus.
module test_plc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import plc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic load_vld = 1'b0;
    logic training = 1'b0;
    plc_cap_load_t load = '0;
    plc_axi_req_t req [2] = '{default: '0};
    plc_axi_rsp_t rsp [2];
    plc_link_ctl_t ctl [2];
    int num_errors = 0;
    int total_checks = 0;
    // Behavioural model of both ports
    int asup [2] = '{3, 3};
    int l0s [2] = '{3, 3};
    int l1 [2] = '{0, 0};
    int clkpm [2] = '{1, 0};
    int pn [2] = '{0, 2};
    int aspm [2] = '{0, 0};
    int ldis [2] = '{0, 0};
    int rtr_n [2] = '{0, 0};
    int rtr_q [2] = '{0, 0};

    always #2 mclk_i = ~mclk_i;

    plc_regs #(.IS_UPSTREAM(1'b1), .PORT_NUM(8'h00)) i_plc_regs (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .axi_i(req[0]), .axi_o(rsp[0]), .cap_load_valid_i(load_vld),
        .cap_load_i(load), .training_i(training), .link_ctl_o(ctl[0]));
    plc_regs #(.IS_UPSTREAM(1'b0), .PORT_NUM(8'h02)) i_plc_regs_dn (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .axi_i(req[1]), .axi_o(rsp[1]), .cap_load_valid_i(load_vld),
        .cap_load_i(load), .training_i(training), .link_ctl_o(ctl[1]));

    // Counts cycles with the retrain request high, so a long pulse shows
    always @(posedge mclk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (ctl[p].retrain === 1'b1) rtr_q[p]++;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] cap_exp(input int p);
        logic dn;
        dn = (p != 0);
        return {pn[p][7:0], 2'b00, dn, 1'b0, dn, clkpm[p][0], l1[p][2:0], l0s[p][2:0],
            asup[p][1:0], 6'h01, 4'h2};
    endfunction

    function automatic logic [31:0] ctl_exp(input int p, input logic trn);
        return {4'h0, trn, 22'h0, ldis[p][0], 2'b00, aspm[p][1:0]};
    endfunction

    task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        @(posedge mclk_i);
        req[p].awvalid <= 1'b1;
        req[p].awaddr <= a;
        req[p].wvalid <= 1'b1;
        req[p].wdata <= d;
        req[p].wstrb <= s;
        req[p].bready <= 1'b1;
        forever begin
            @(posedge mclk_i);
            if (req[p].awvalid && rsp[p].awready) req[p].awvalid <= 1'b0;
            if (req[p].wvalid && rsp[p].wready) req[p].wvalid <= 1'b0;
            if (rsp[p].bvalid === 1'b1) begin
                req[p].bready <= 1'b0;
                chk({30'h0, rsp[p].bresp}, {30'h0, er});
                break;
            end
        end
    endtask

    task automatic rd_chk(input int p, input logic [7:0] a, input logic [31:0] exp,
        input logic [1:0] er);
        @(posedge mclk_i);
        req[p].arvalid <= 1'b1;
        req[p].araddr <= a;
        req[p].rready <= 1'b1;
        forever begin
            @(posedge mclk_i);
            if (req[p].arvalid && rsp[p].arready) req[p].arvalid <= 1'b0;
            if (rsp[p].rvalid === 1'b1) begin
                req[p].rready <= 1'b0;
                chk(rsp[p].rdata, exp);
                chk({30'h0, rsp[p].rresp}, {30'h0, er});
                break;
            end
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(4 * 20000);
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] d;
        void'($urandom(76597));
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            chk({27'h0, ctl[p]}, 32'h1);
            rd_chk(p, PLC_OFS_CAP, cap_exp(p), 2'h0);
            for (int c = 0; c < 4; c++) begin
                d = $urandom;
                d[1:0] = c[1:0];
                d[4] = c[0];
                d[5] = 1'b1;
                wr(p, PLC_OFS_CTL, d, 4'hF, 2'h0);
                aspm[p] = c;
                ldis[p] = (p == 0) ? 0 : c % 2;
                rtr_n[p] += p;
                rd_chk(p, PLC_OFS_CTL, ctl_exp(p, 1'b0), 2'h0);
                chk({27'h0, ctl[p]}, {27'h0, aspm[p][1:0], ldis[p][0], 2'b01});
            end
            chk(rtr_q[p], rtr_n[p]);
            wr(p, PLC_OFS_CTL, 32'h0, 4'hE, 2'h0);
            rd_chk(p, PLC_OFS_CTL, ctl_exp(p, 1'b0), 2'h0);
            wr(p, PLC_OFS_CAP, $urandom, 4'hF, 2'h0);
            rd_chk(p, PLC_OFS_CAP, cap_exp(p), 2'h0);
            wr(p, 8'h40, $urandom, 4'hF, PLC_RESP_SLVERR);
            rd_chk(p, 8'h40, 32'h0, PLC_RESP_SLVERR);
            training <= 1'b1;
            rd_chk(p, PLC_OFS_CTL, ctl_exp(p, 1'b1), 2'h0);
            training <= 1'b0;
            rd_chk(p, PLC_OFS_CTL, ctl_exp(p, 1'b0), 2'h0);
        end
        // New defaults reach both ports at once
        d = $urandom;
        load_vld <= 1'b1;
        load <= d[16:0];
        @(posedge mclk_i);
        load_vld <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            asup[p] = load.aspm_sup;
            l0s[p] = load.l0s_lat;
            l1[p] = load.l1_lat;
            clkpm[p] = load.clkpm;
            pn[p] = load.port_num;
            rd_chk(p, PLC_OFS_CAP, cap_exp(p), 2'h0);
        end
        report_and_stop();
    end
endmodule // test_plc_regs
